/* pkg/sba_pkg.sv */
// Package holding constants, block codes and carriers of the socket buffer allocator.
`default_nettype none
package sba_pkg;
    localparam int NSOCK = 8;
    localparam int MEM_BYTES = 16384;
    localparam int UNIT_SHIFT = 10;
    localparam int REG_SPAN = 48;
    localparam logic [15:0] OFS_RESERVED = 16'h0030;
    localparam logic [5:0] OFS_MODE = 6'h00;
    localparam logic [5:0] OFS_COMMAND = 6'h01;
    localparam logic [5:0] OFS_IRQ_FLAGS = 6'h02;
    localparam logic [5:0] OFS_STATE = 6'h03;
    localparam logic [5:0] OFS_LOCAL_PORT = 6'h04;
    localparam logic [5:0] OFS_PEER_HW = 6'h06;
    localparam logic [5:0] OFS_PEER_IP = 6'h0C;
    localparam logic [5:0] OFS_PEER_PORT = 6'h10;
    localparam logic [5:0] OFS_MAX_SEG = 6'h12;
    localparam logic [5:0] OFS_GAP_A = 6'h14;
    localparam logic [5:0] OFS_SERVICE = 6'h15;
    localparam logic [5:0] OFS_HOP = 6'h16;
    localparam logic [5:0] OFS_GAP_B_LO = 6'h17;
    localparam logic [5:0] OFS_GAP_B_HI = 6'h1D;
    localparam logic [5:0] OFS_RX_SIZE = 6'h1E;
    localparam logic [5:0] OFS_TX_SIZE = 6'h1F;
    localparam logic [5:0] OFS_TX_FREE = 6'h20;
    localparam logic [5:0] OFS_TX_CONSUME = 6'h22;
    localparam logic [5:0] OFS_TX_PRODUCE = 6'h24;
    localparam logic [5:0] OFS_RX_PENDING = 6'h26;
    localparam logic [5:0] OFS_RX_CONSUME = 6'h28;
    localparam logic [5:0] OFS_RX_PRODUCE = 6'h2A;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h2C;
    localparam logic [5:0] OFS_FRAGMENT = 6'h2D;
    localparam logic [5:0] OFS_KEEPALIVE = 6'h2F;
    localparam logic [7:0] SIZE_RST = 8'h02;
    localparam logic [7:0] BYTE_RST = 8'h00;
    typedef enum logic [1:0] {
        SBA_BLK_COMMON = 2'b00,
        SBA_BLK_REG = 2'b01,
        SBA_BLK_TXB = 2'b10,
        SBA_BLK_RXB = 2'b11
    } sba_blk_e;
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] block_select_field;
        logic [15:0] offset;
        logic [7:0] wdata;
    } sba_host_req_s;
    typedef struct packed {
        logic valid;
        logic op_rx;
        logic [2:0] sock;
        logic [7:0] wdata;
        logic [7:0] irq_set;
    } sba_eng_req_s;
endpackage
`default_nettype wire

/* hdl/sba_region_map.sv */
// Region layout of one shared buffer memory and offset translation.
`default_nettype none
module sba_region_map #(
    parameter int NSOCK = 8,
    parameter int MEM_BYTES = 16384
) (
    input wire logic [NSOCK-1:0][7:0] size_codes,
    input wire logic [$clog2(NSOCK)-1:0] sel_a,
    input wire logic [15:0] off_a,
    output logic [$clog2(MEM_BYTES)-1:0] phys_a,
    output logic ok_a,
    output logic [15:0] bytes_a,
    input wire logic [$clog2(NSOCK)-1:0] sel_b,
    input wire logic [15:0] off_b,
    output logic [$clog2(MEM_BYTES)-1:0] phys_b,
    output logic ok_b,
    output logic [15:0] bytes_b
);
    localparam int AW = $clog2(MEM_BYTES);
    logic [17:0] base [NSOCK];
    logic [17:0] bytes [NSOCK];
    logic [17:0] acc;
    logic [17:0] sum_a;
    logic [17:0] sum_b;

    if (MEM_BYTES > 65536 || (1 << AW) != MEM_BYTES || NSOCK < 2)
    begin : g_bad_cfg
        $error("Unsupported memory size or socket count.");
    end

    function automatic logic [17:0] code_bytes(input logic [7:0] code);
        case (code)
            8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10:
                code_bytes = {10'h000, code} << sba_pkg::UNIT_SHIFT;
            default:
                code_bytes = 18'h00000;
        endcase
    endfunction

    // Regions are packed in socket order; an oversized total wraps, as the host was warned.
    always_comb
    begin
        acc = 18'h00000;
        for (int i = 0; i < NSOCK; i++)
        begin
            bytes[i] = code_bytes(size_codes[i]);
            base[i] = acc; // RULE6 RULE9
            acc = acc + bytes[i];
        end
        sum_a = base[sel_a] + ({2'b00, off_a} & (bytes[sel_a] - 18'h00001)); // RULE15 RULE16
        sum_b = base[sel_b] + ({2'b00, off_b} & (bytes[sel_b] - 18'h00001)); // RULE15 RULE16
        phys_a = sum_a[AW-1:0];
        phys_b = sum_b[AW-1:0];
        ok_a = bytes[sel_a] != 18'h00000;
        ok_b = bytes[sel_b] != 18'h00000;
        bytes_a = bytes[sel_a][15:0];
        bytes_b = bytes[sel_b][15:0];
    end
endmodule
`default_nettype wire

/* hdl/sba_socket_buffer.sv */
// Per-socket register blocks and shared transmit and receive buffer memories.
// Functional notes
// RULE1 - Eight sockets; the block select field picks which socket block is accessed.
// RULE2 - Socket registers use 16-bit offsets; 0x0030 upward is reserved and reads zero.
// RULE3 - One shared 16KB transmit memory and one shared 16KB receive memory.
// RULE4 - After reset each transmit region is 2KB, eight filling the memory.
// RULE5 - Host writes to the transmit size register change the transmit layout.
// RULE6 - Transmit regions sit back to back from socket 0 to socket 7.
// RULE7 - Host keeps the sum of transmit sizes at or below 16KB.
// RULE8 - After reset each receive region is 2KB; size follows its register.
// RULE9 - Receive regions sit back to back from socket 0 to socket 7.
// RULE10 - Host keeps the sum of receive sizes at or below 16KB.
// RULE11 - Host writes transmit data through a 64KB logical offset space.
// RULE12 - Received data lands in the buffer; host reads it through 64KB offsets.
// RULE13 - Transmit data lies between host produce pointer and device consume pointer.
// RULE14 - Receive data lies between device produce pointer and host consume pointer.
// RULE15 - Every logical offset is translated to a physical address inside the region.
// RULE16 - Offsets wrap modulo the region size and add the region base.
`default_nettype none
module sba_socket_buffer #(
    parameter int NSOCK = sba_pkg::NSOCK,
    parameter int MEM_BYTES = sba_pkg::MEM_BYTES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire sba_pkg::sba_host_req_s host_req,
    output logic [7:0] host_rdata_r,
    output logic host_ack_r,
    input wire sba_pkg::sba_eng_req_s eng_req,
    output logic [7:0] eng_rdata_r,
    output logic eng_ack_r,
    output logic eng_ok_r
);
    localparam int AW = $clog2(MEM_BYTES);
    localparam int SW = $clog2(NSOCK);
    localparam int SPAN = sba_pkg::REG_SPAN;

    // The block select field carries the socket number in only three bits.
    if (NSOCK != 8 || MEM_BYTES != 16384)
    begin : g_bad_cfg
        $error("Block select decoding serves eight sockets and 16KB memories only.");
    end

    logic [7:0] cfg_r [NSOCK][SPAN];
    logic [7:0] tx_mem_r [MEM_BYTES];
    logic [7:0] rx_mem_r [MEM_BYTES];
    logic [NSOCK-1:0][7:0] tx_codes;
    logic [NSOCK-1:0][7:0] rx_codes;
    logic [15:0] tx_prod [NSOCK];
    logic [15:0] tx_cons [NSOCK];
    logic [15:0] rx_prod [NSOCK];
    logic [15:0] rx_cons [NSOCK];
    logic [7:0] irq_nxt [NSOCK];

    sba_pkg::sba_blk_e kind;
    logic [SW-1:0] hsock;
    logic [SW-1:0] esock;
    logic [5:0] hofs;
    logic in_regs;
    logic reg_wr;
    logic [AW-1:0] tx_phys_a;
    logic [AW-1:0] tx_phys_b;
    logic [AW-1:0] rx_phys_a;
    logic [AW-1:0] rx_phys_b;
    logic tx_ok_a;
    logic tx_ok_b;
    logic rx_ok_a;
    logic rx_ok_b;
    logic [15:0] tx_bytes_a;
    logic [15:0] rx_bytes_b;
    logic [15:0] tx_free;
    logic [15:0] rx_pending;
    logic eng_tx_ok;
    logic eng_rx_ok;
    logic [7:0] rd_byte;

    // Block select field: socket number in the upper bits, block kind in the lower two.
    assign kind = sba_pkg::sba_blk_e'(host_req.block_select_field[1:0]); // RULE1
    assign hsock = host_req.block_select_field[4:2]; // RULE1
    assign esock = eng_req.sock;
    assign hofs = host_req.offset[5:0];
    assign in_regs = host_req.offset < sba_pkg::OFS_RESERVED; // RULE2
    assign reg_wr = host_req.valid && host_req.write && kind == sba_pkg::SBA_BLK_REG && in_regs;

    for (genvar s = 0; s < NSOCK; s++)
    begin : g_view
        assign tx_codes[s] = cfg_r[s][sba_pkg::OFS_TX_SIZE];
        assign rx_codes[s] = cfg_r[s][sba_pkg::OFS_RX_SIZE];
        assign tx_prod[s] = {cfg_r[s][sba_pkg::OFS_TX_PRODUCE],
            cfg_r[s][sba_pkg::OFS_TX_PRODUCE+1]};
        assign tx_cons[s] = {cfg_r[s][sba_pkg::OFS_TX_CONSUME],
            cfg_r[s][sba_pkg::OFS_TX_CONSUME+1]};
        assign rx_prod[s] = {cfg_r[s][sba_pkg::OFS_RX_PRODUCE],
            cfg_r[s][sba_pkg::OFS_RX_PRODUCE+1]};
        assign rx_cons[s] = {cfg_r[s][sba_pkg::OFS_RX_CONSUME],
            cfg_r[s][sba_pkg::OFS_RX_CONSUME+1]};
    end

    sba_region_map #(.NSOCK(NSOCK), .MEM_BYTES(MEM_BYTES)) u_tx_map (
        .size_codes(tx_codes),
        .sel_a(hsock),
        .off_a(host_req.offset),
        .phys_a(tx_phys_a),
        .ok_a(tx_ok_a),
        .bytes_a(tx_bytes_a),
        .sel_b(esock),
        .off_b(tx_cons[esock]),
        .phys_b(tx_phys_b),
        .ok_b(tx_ok_b),
        .bytes_b()
    );

    sba_region_map #(.NSOCK(NSOCK), .MEM_BYTES(MEM_BYTES)) u_rx_map (
        .size_codes(rx_codes),
        .sel_a(hsock),
        .off_a(host_req.offset),
        .phys_a(rx_phys_a),
        .ok_a(rx_ok_a),
        .bytes_a(),
        .sel_b(esock),
        .off_b(rx_prod[esock]),
        .phys_b(rx_phys_b),
        .ok_b(rx_ok_b),
        .bytes_b(rx_bytes_b)
    );

    // Free space and pending counts come from pointer distance, so wrapping at 0xFFFF is harmless.
    assign tx_free = tx_bytes_a - (tx_prod[hsock] - tx_cons[hsock]); // RULE13
    assign rx_pending = rx_prod[hsock] - rx_cons[hsock]; // RULE14
    assign eng_tx_ok = eng_req.valid && !eng_req.op_rx && tx_ok_b
        && tx_prod[esock] != tx_cons[esock]; // RULE13
    assign eng_rx_ok = eng_req.valid && eng_req.op_rx && rx_ok_b
        && (rx_prod[esock] - rx_cons[esock]) < rx_bytes_b; // RULE14

    function automatic logic [7:0] reset_byte(input int ofs);
        if (ofs == int'(sba_pkg::OFS_TX_SIZE) || ofs == int'(sba_pkg::OFS_RX_SIZE))
            reset_byte = sba_pkg::SIZE_RST;
        else
            reset_byte = sba_pkg::BYTE_RST;
    endfunction

    // Read-only, reserved and flag offsets are not plain storage for host writes.
    function automatic logic host_writable(input logic [5:0] ofs);
        case (ofs)
            sba_pkg::OFS_IRQ_FLAGS, sba_pkg::OFS_STATE, sba_pkg::OFS_GAP_A,
            sba_pkg::OFS_TX_FREE, sba_pkg::OFS_TX_FREE + 6'h01,
            sba_pkg::OFS_TX_CONSUME, sba_pkg::OFS_TX_CONSUME + 6'h01,
            sba_pkg::OFS_RX_PENDING, sba_pkg::OFS_RX_PENDING + 6'h01,
            sba_pkg::OFS_RX_PRODUCE, sba_pkg::OFS_RX_PRODUCE + 6'h01:
                host_writable = 1'b0;
            default:
                host_writable = !(ofs >= sba_pkg::OFS_GAP_B_LO && ofs <= sba_pkg::OFS_GAP_B_HI);
        endcase
    endfunction

    // Engine events set flags after the host clear is applied, so a same-cycle event survives.
    always_comb
    begin
        for (int s = 0; s < NSOCK; s++)
        begin
            irq_nxt[s] = cfg_r[s][sba_pkg::OFS_IRQ_FLAGS];
            if (reg_wr && hofs == sba_pkg::OFS_IRQ_FLAGS && hsock == SW'(s))
                irq_nxt[s] = irq_nxt[s] & ~host_req.wdata;
            if (esock == SW'(s))
                irq_nxt[s] = irq_nxt[s] | eng_req.irq_set;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (int s = 0; s < NSOCK; s++)
                for (int o = 0; o < SPAN; o++)
                    cfg_r[s][o] <= reset_byte(o); // RULE4 RULE8
        end
        else
        begin
            if (reg_wr && host_writable(hofs))
                cfg_r[hsock][hofs] <= host_req.wdata; // RULE5 RULE8
            if (eng_tx_ok)
                {cfg_r[esock][sba_pkg::OFS_TX_CONSUME], cfg_r[esock][sba_pkg::OFS_TX_CONSUME+1]}
                    <= tx_cons[esock] + 16'h0001; // RULE13
            if (eng_rx_ok)
                {cfg_r[esock][sba_pkg::OFS_RX_PRODUCE], cfg_r[esock][sba_pkg::OFS_RX_PRODUCE+1]}
                    <= rx_prod[esock] + 16'h0001; // RULE14
            for (int s = 0; s < NSOCK; s++)
                cfg_r[s][sba_pkg::OFS_IRQ_FLAGS] <= irq_nxt[s];
        end
    end

    // Buffer storage has no reset; software never reads a byte it has not first produced.
    always_ff @(posedge core_clk)
    begin
        if (host_req.valid && host_req.write && kind == sba_pkg::SBA_BLK_TXB && tx_ok_a)
            tx_mem_r[tx_phys_a] <= host_req.wdata; // RULE3 RULE11
    end

    always_ff @(posedge core_clk)
    begin
        if (eng_rx_ok)
            rx_mem_r[rx_phys_b] <= eng_req.wdata; // RULE3 RULE12
    end

    always_comb
    begin
        rd_byte = 8'h00;
        case (kind)
            sba_pkg::SBA_BLK_REG:
            begin
                if (in_regs) // RULE2
                begin
                    case (hofs)
                        sba_pkg::OFS_TX_FREE: rd_byte = tx_free[15:8];
                        sba_pkg::OFS_TX_FREE + 6'h01: rd_byte = tx_free[7:0];
                        sba_pkg::OFS_RX_PENDING: rd_byte = rx_pending[15:8];
                        sba_pkg::OFS_RX_PENDING + 6'h01: rd_byte = rx_pending[7:0];
                        default: rd_byte = cfg_r[hsock][hofs];
                    endcase
                end
            end
            sba_pkg::SBA_BLK_TXB:
                rd_byte = tx_ok_a ? tx_mem_r[tx_phys_a] : 8'h00;
            sba_pkg::SBA_BLK_RXB:
                rd_byte = rx_ok_a ? rx_mem_r[rx_phys_a] : 8'h00; // RULE12
            default:
                rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            host_ack_r <= 1'b0;
            host_rdata_r <= 8'h00;
        end
        else
        begin
            host_ack_r <= host_req.valid;
            host_rdata_r <= (host_req.valid && !host_req.write) ? rd_byte : 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            eng_ack_r <= 1'b0;
            eng_ok_r <= 1'b0;
            eng_rdata_r <= 8'h00;
        end
        else
        begin
            eng_ack_r <= eng_req.valid;
            eng_ok_r <= eng_tx_ok || eng_rx_ok;
            eng_rdata_r <= eng_tx_ok ? tx_mem_r[tx_phys_b] : 8'h00; // RULE13
        end
    end

    host_ack_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        host_req.valid |=> host_ack_r)
        else $error("Host request not answered next cycle.");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE2
        host_req.valid && !host_req.write && kind == sba_pkg::SBA_BLK_REG && !in_regs
        |=> host_rdata_r == 8'h00)
        else $error("Reserved offset read not zero.");

    tx_size_reset_a: assert property (@(posedge core_clk) // RULE4
        !rst_b ##1 rst_b |-> tx_codes == {NSOCK{sba_pkg::SIZE_RST}})
        else $error("Transmit sizes not 2KB after reset.");

    rx_size_reset_a: assert property (@(posedge core_clk) // RULE8
        !rst_b ##1 rst_b |-> rx_codes == {NSOCK{sba_pkg::SIZE_RST}})
        else $error("Receive sizes not 2KB after reset.");

    size_write_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE5
        reg_wr && hofs == sba_pkg::OFS_TX_SIZE
        |=> tx_codes[$past(hsock)] == $past(host_req.wdata))
        else $error("Transmit size write not applied.");

    tx_consume_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
        eng_tx_ok |=> eng_ok_r && tx_cons[$past(esock)] == $past(tx_cons[esock]) + 16'h0001)
        else $error("Transmit consume pointer did not advance.");

    rx_produce_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE14
        eng_rx_ok |=> rx_mem_r[$past(rx_phys_b)] == $past(eng_req.wdata)
        && rx_prod[$past(esock)] == $past(rx_prod[esock]) + 16'h0001)
        else $error("Received byte or produce pointer wrong.");

    tx_store_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE11
        host_req.valid && host_req.write && kind == sba_pkg::SBA_BLK_TXB && tx_ok_a
        |=> tx_mem_r[$past(tx_phys_a)] == $past(host_req.wdata))
        else $error("Transmit byte not stored.");

    layout_order_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE6
        kind == sba_pkg::SBA_BLK_TXB && hsock == 3'h1 && host_req.offset == 16'h0000
        && tx_codes[0] == sba_pkg::SIZE_RST && tx_ok_a
        |-> tx_phys_a == AW'(2048))
        else $error("Socket 1 region does not follow socket 0.");

    wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE16
        kind == sba_pkg::SBA_BLK_TXB && tx_ok_a
        |-> (tx_phys_a - u_tx_map.base[hsock][AW-1:0])
        == AW'(host_req.offset & (tx_bytes_a - 16'h0001)))
        else $error("Offset not wrapped into region.");

    irq_set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        eng_req.irq_set != 8'h00
        |=> (cfg_r[$past(esock)][sba_pkg::OFS_IRQ_FLAGS] & $past(eng_req.irq_set))
        == $past(eng_req.irq_set))
        else $error("Interrupt flag set was lost.");

    tx_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13
        eng_req.valid && !eng_req.op_rx && !eng_tx_ok
        |=> !eng_ok_r && eng_rdata_r == 8'h00 && tx_cons[$past(esock)] == $past(tx_cons[esock]))
        else $error("Refused transmit take changed state.");

    rx_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE14
        eng_req.valid && eng_req.op_rx && !eng_rx_ok
        |=> !eng_ok_r && rx_prod[$past(esock)] == $past(rx_prod[esock]))
        else $error("Refused receive store changed state.");

    write_rdata_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE1
        host_req.valid && host_req.write |=> host_rdata_r == 8'h00)
        else $error("Write answered with nonzero data.");

    eng_ack_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE13 RULE14
        eng_req.valid |=> eng_ack_r)
        else $error("Engine request not answered next cycle.");

    rx_size_write_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
        reg_wr && hofs == sba_pkg::OFS_RX_SIZE
        |=> rx_codes[$past(hsock)] == $past(host_req.wdata))
        else $error("Receive size write not applied.");

    cover_tx_c: cover property (@(posedge core_clk) disable iff (!rst_b) eng_tx_ok);
    cover_rx_c: cover property (@(posedge core_clk) disable iff (!rst_b) eng_rx_ok);
    cover_resize_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        reg_wr && hofs == sba_pkg::OFS_RX_SIZE);
    cover_rx_full_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        eng_req.valid && eng_req.op_rx && !eng_rx_ok);
    cover_irq_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        eng_req.irq_set != 8'h00);
endmodule
`default_nettype wire

/* sim/sba_host_model.sv */
// Host controller model issuing single byte accesses to the socket buffer block.
`default_nettype none
module sba_host_model (
    input wire logic core_clk,
    output var sba_pkg::sba_host_req_s host_req,
    input wire logic [7:0] host_rdata_r,
    input wire logic host_ack_r
);
    timeunit 1ns;
    timeprecision 1ps;

    initial host_req = '0;

    // One byte per frame, socket and kind in the block select field.
    task automatic access(input logic wr, input logic [4:0] bsf, input logic [15:0] ofs,
        input logic [7:0] wd, output logic [7:0] rd, output logic seen);
        int n;
        seen = 1'b0;
        rd = 8'h00;
        @(posedge core_clk);
        host_req <= '{valid: 1'b1, write: wr, block_select_field: bsf, offset: ofs,
            wdata: wd};
        @(posedge core_clk);
        // Released fields flip so that a stale value cannot pass for a held one.
        host_req <= '{valid: 1'b0, write: ~wr, block_select_field: ~bsf, offset: ~ofs,
            wdata: ~wd};
        for (n = 0; n < 4 && !seen; n++)
        begin
            #1;
            if (host_ack_r === 1'b1)
            begin
                seen = 1'b1;
                rd = host_rdata_r;
            end
            else
                @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

/* sim/test_sba_socket_buffer.sv */
// Self-checking bench of the socket buffer allocator through its host and engine ports.
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp); \
        end \
    end
module test_sba_socket_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    sba_pkg::sba_host_req_s host_req;
    sba_pkg::sba_eng_req_s eng_req = '0;
    logic [7:0] host_rdata_r;
    logic [7:0] eng_rdata_r;
    logic host_ack_r;
    logic eng_ack_r;
    logic eng_ok_r;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic seen;
    logic [15:0] dead [6] = '{16'h0003, 16'h0014, 16'h001D, 16'h0022, 16'h0030, 16'hFFFF};

    always #4 core_clk = ~core_clk;

    sba_socket_buffer i_dut (.core_clk(core_clk), .rst_b(rst_b), .host_req(host_req),
        .host_rdata_r(host_rdata_r), .host_ack_r(host_ack_r), .eng_req(eng_req),
        .eng_rdata_r(eng_rdata_r), .eng_ack_r(eng_ack_r), .eng_ok_r(eng_ok_r));
    sba_host_model i_host (.core_clk(core_clk), .host_req(host_req),
        .host_rdata_r(host_rdata_r), .host_ack_r(host_ack_r));

    function automatic logic [4:0] b_reg(input logic [2:0] s);
        return {s, sba_pkg::SBA_BLK_REG};
    endfunction
    function automatic logic [4:0] b_tx(input logic [2:0] s);
        return {s, sba_pkg::SBA_BLK_TXB};
    endfunction
    function automatic logic [4:0] b_rx(input logic [2:0] s);
        return {s, sba_pkg::SBA_BLK_RXB};
    endfunction

    task automatic wr(input logic [4:0] bsf, input logic [15:0] ofs, input logic [7:0] d);
        i_host.access(1'b1, bsf, ofs, d, rd, seen);
        `CHK(seen, 1'b1)
    endtask
    task automatic rd_chk(input logic [4:0] bsf, input logic [15:0] ofs, input logic [7:0] e);
        i_host.access(1'b0, bsf, ofs, 8'h00, rd, seen);
        `CHK(seen, 1'b1)
        `CHK(rd, e)
    endtask
    // Sixteen-bit registers are big-endian: the lower offset holds the high byte.
    task automatic wr16(input logic [2:0] s, input logic [5:0] o, input logic [15:0] v);
        wr(b_reg(s), {10'h000, o}, v[15:8]);
        wr(b_reg(s), {10'h000, o} + 16'h0001, v[7:0]);
    endtask
    task automatic rd16(input logic [2:0] s, input logic [5:0] o, input logic [15:0] v);
        rd_chk(b_reg(s), {10'h000, o}, v[15:8]);
        rd_chk(b_reg(s), {10'h000, o} + 16'h0001, v[7:0]);
    endtask
    task automatic eng(input logic rx, input logic [2:0] s, input logic [7:0] d,
        input logic ok, input logic [7:0] e);
        @(posedge core_clk);
        eng_req <= '{valid: 1'b1, op_rx: rx, sock: s, wdata: d, irq_set: 8'h00};
        @(posedge core_clk);
        eng_req <= '{valid: 1'b0, op_rx: ~rx, sock: ~s, wdata: ~d, irq_set: 8'h00};
        #1;
        `CHK(eng_ack_r, 1'b1)
        `CHK(eng_ok_r, ok)
        `CHK(eng_rdata_r, e)
    endtask

    task automatic results();
        $display("Checks: %0d, failures: %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            results();
        end
    end

    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int s = 0; s < 8; s++)
        begin
            rd_chk(b_reg(s[2:0]), 16'h001E, 8'h02);
            rd_chk(b_reg(s[2:0]), 16'h001F, 8'h02);
            wr(b_reg(s[2:0]), 16'h0000, 8'h40 + s[7:0]);
        end
        for (int s = 0; s < 8; s++)
            rd_chk(b_reg(s[2:0]), 16'h0000, 8'h40 + s[7:0]);
        foreach (dead[i])
        begin
            wr(b_reg(3'd0), dead[i], 8'hA5);
            rd_chk(b_reg(3'd0), dead[i], 8'h00);
        end
        rd_chk({3'd0, sba_pkg::SBA_BLK_COMMON}, 16'h0000, 8'h00);
        // With reset sizes socket 1 starts right after the 2KB of socket 0.
        wr(b_tx(3'd1), 16'h0000, 8'h3C);
        rd_chk(b_tx(3'd1), 16'h0800, 8'h3C);
        // Interrupt flags clear by writing ones.
        @(posedge core_clk);
        eng_req <= '{valid: 1'b0, op_rx: 1'b0, sock: 3'd2, wdata: 8'h00, irq_set: 8'h05};
        @(posedge core_clk);
        eng_req.irq_set <= 8'h00;
        rd_chk(b_reg(3'd2), 16'h0002, 8'h05);
        wr(b_reg(3'd2), 16'h0002, 8'h01);
        rd_chk(b_reg(3'd2), 16'h0002, 8'h04);
        // Transmit path of socket 3; offset 0x0800 folds onto 0 in a 2KB region.
        rd16(3'd3, sba_pkg::OFS_TX_FREE, 16'h0800);
        wr(b_tx(3'd3), 16'h0800, 8'h5A);
        wr16(3'd3, sba_pkg::OFS_TX_PRODUCE, 16'h0001);
        rd16(3'd3, sba_pkg::OFS_TX_FREE, 16'h07FF);
        eng(1'b0, 3'd3, 8'h00, 1'b1, 8'h5A);
        eng(1'b0, 3'd3, 8'h00, 1'b0, 8'h00);
        rd16(3'd3, sba_pkg::OFS_TX_CONSUME, 16'h0001);
        // Socket 3 grows to 4KB while 4 and 5 shrink, keeping the sum at 16.
        wr(b_reg(3'd4), 16'h001F, 8'h01);
        wr(b_reg(3'd5), 16'h001F, 8'h01);
        wr(b_reg(3'd3), 16'h001F, 8'h04);
        rd16(3'd3, sba_pkg::OFS_TX_FREE, 16'h1000);
        wr(b_tx(3'd3), 16'h1801, 8'h77);
        rd_chk(b_tx(3'd3), 16'h0801, 8'h77);
        rd_chk(b_tx(3'd3), 16'hF801, 8'h77);
        // Oversizing socket 0 on purpose makes the next regions fold onto its own.
        wr(b_reg(3'd0), 16'h001F, 8'h10);
        wr(b_tx(3'd1), 16'h0003, 8'hA1);
        wr(b_tx(3'd2), 16'h0005, 8'hB2);
        rd_chk(b_tx(3'd0), 16'h0003, 8'hA1);
        rd_chk(b_tx(3'd0), 16'h0805, 8'hB2);
        wr(b_reg(3'd0), 16'h001F, 8'h02);
        wr(b_reg(3'd0), 16'h001E, 8'h10);
        eng(1'b1, 3'd1, 8'hC3, 1'b1, 8'h00);
        rd_chk(b_rx(3'd0), 16'h0000, 8'hC3);
        // Socket 1 still folds onto the start of memory until socket 0 shrinks back.
        wr(b_rx(3'd1), 16'h0000, 8'hFF);
        rd_chk(b_rx(3'd1), 16'h0000, 8'hC3);
        wr(b_reg(3'd0), 16'h001E, 8'h02);
        rd16(3'd1, sba_pkg::OFS_RX_PENDING, 16'h0001);
        rd16(3'd1, sba_pkg::OFS_RX_PRODUCE, 16'h0001);
        wr16(3'd1, sba_pkg::OFS_RX_CONSUME, 16'h0001);
        rd16(3'd1, sba_pkg::OFS_RX_PENDING, 16'h0000);
        // A zero-size region takes nothing; a 1KB region takes exactly 1024 bytes.
        wr(b_reg(3'd5), 16'h001E, 8'h00);
        eng(1'b1, 3'd5, 8'h11, 1'b0, 8'h00);
        wr(b_reg(3'd6), 16'h001E, 8'h01);
        for (int i = 0; i < 1024; i++)
            eng(1'b1, 3'd6, i[7:0], 1'b1, 8'h00);
        eng(1'b1, 3'd6, 8'h99, 1'b0, 8'h00);
        rd16(3'd6, sba_pkg::OFS_RX_PENDING, 16'h0400);
        rd_chk(b_rx(3'd6), 16'hFBFF, 8'hFF);
        results();
    end
endmodule
`undef CHK
`default_nettype wire
